/* rtl/cpu_seq_params.svh */
// Offsets, field positions, reset values, timing counts and opcodes of the cycle sequencer
`ifndef CPU_SEQ_PARAMS_SVH
`define CPU_SEQ_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PC 8'h08
`define OFS_POINTER 8'h0C
`define OFS_ACC 8'h10
`define OFS_RI 8'h14
`define OFS_OPCODE 8'h18
`define OFS_ASW 8'hD0
// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_RUN 0
`define CTRL_IROM 1
`define ASW_CY 7
`define ASW_AC 6
`define ASW_OV 2
`define PC_RST 16'h0000
`define ASW_RST 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ****************************************
// Timing and memory split
// ****************************************
`define CLKS_PER_STATE 4'h2
`define IROM_TOP 16'h3FFF
// ****************************************
// Opcodes known to the decode array
// ****************************************
`define OP_MUL 8'hA4
`define OP_DIV 8'h84
`define OP_RD_PTR 8'hE0
`define OP_WR_PTR 8'hF0
`define OP_RD_R0 8'hE2
`define OP_RD_R1 8'hE3
`define OP_WR_R0 8'hF2
`define OP_WR_R1 8'hF3
`define OP_MOV_PTR 8'h90
`define OP_MOV_A 8'h74
`define OP_ADD 8'h24
`define OP_ADDC 8'h34
`define OP_SUBB 8'h94
`endif

/* rtl/cpu_seq_pkg.sv */
// Types and the decode array of the machine-cycle sequencer
`include "cpu_seq_params.svh"
package cpu_seq_pkg;
    typedef enum logic [5:0] {ST1 = 6'h01, ST2 = 6'h02, ST3 = 6'h04,
        ST4 = 6'h08, ST5 = 6'h10, ST6 = 6'h20} mstate_t;
    typedef enum logic [1:0] {XM_NONE = 2'h0, XM_READ = 2'h1, XM_WRITE = 2'h2} xmove_t;
    typedef enum logic [1:0] {AR_NONE = 2'h0, AR_ADD = 2'h1, AR_ADDC = 2'h2,
        AR_SUBB = 2'h3} arith_t;
    typedef struct packed {
        logic [1:0] last_mc;
        logic [1:0] nbytes;
        xmove_t xmove;
        logic use_ptr;
        arith_t arith;
        logic load_acc;
        logic load_ptr;
    } decode_t;
    typedef struct packed {
        mstate_t st;
        logic last;
    } timing_t;
    typedef struct packed {
        mstate_t st;
        logic [3:0] cnt;
    } div_t;
    typedef struct packed {
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic aw_held, w_held;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic run, irom;
        logic [15:0] pc, ptr, operand;
        logic [7:0] acc, ri, asw, opcode;
        logic [1:0] mc;
        logic active;
        decode_t info;
        logic data_slot, slot_ext;
        logic [15:0] slot_addr;
        logic ale, fetch_n, rd_n, wr_n, p0_oe;
        logic [7:0] p0_out, p2_out, p0_s1, p0_s2;
    } core_t;
    localparam decode_t DEC_IDLE = '{2'h0, 2'h1, XM_NONE, 1'b0, AR_NONE, 1'b0, 1'b0};

    // Decode array: opcode to cycle count, length and side effects
    function automatic decode_t decode_array(input logic [7:0] op);
        decode_t d;
        d = DEC_IDLE;
        case (op)
            `OP_MUL, `OP_DIV: d.last_mc = 2'h3;
            `OP_RD_PTR, `OP_WR_PTR, `OP_RD_R0, `OP_RD_R1, `OP_WR_R0, `OP_WR_R1: begin
                d.last_mc = 2'h1;
                d.xmove = op[4] ? XM_WRITE : XM_READ;
                d.use_ptr = !op[1];
            end
            `OP_MOV_PTR: begin
                d.last_mc = 2'h1;
                d.nbytes = 2'h3;
                d.load_ptr = 1'b1;
            end
            `OP_MOV_A: begin
                d.nbytes = 2'h2;
                d.load_acc = 1'b1;
            end
            `OP_ADD, `OP_ADDC, `OP_SUBB: begin
                d.nbytes = 2'h2;
                d.arith = (op == `OP_ADD) ? AR_ADD : ((op == `OP_ADDC) ? AR_ADDC : AR_SUBB);
            end
            default: d = DEC_IDLE;
        endcase
        return d;
    endfunction
endpackage

/* rtl/state_divider.sv */
// Divides the oscillator clock into six two-clock states per machine cycle
`timescale 1ns/1ps
`include "cpu_seq_params.svh"
module state_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // State and last-clock-of-state flag
    output cpu_seq_pkg::timing_t tim
);
    cpu_seq_pkg::div_t r;
    cpu_seq_pkg::div_t next_r;

    // ****************************************
    // State counter
    // ****************************************
    // Count clocks within a state, then step to the next state
    always_comb begin
        next_r = r;
        if (r.cnt == `CLKS_PER_STATE - 4'h1) begin
            next_r.cnt = 4'h0;
            unique case (r.st)
                cpu_seq_pkg::ST1: next_r.st = cpu_seq_pkg::ST2;
                cpu_seq_pkg::ST2: next_r.st = cpu_seq_pkg::ST3;
                cpu_seq_pkg::ST3: next_r.st = cpu_seq_pkg::ST4;
                cpu_seq_pkg::ST4: next_r.st = cpu_seq_pkg::ST5;
                cpu_seq_pkg::ST5: next_r.st = cpu_seq_pkg::ST6;
                cpu_seq_pkg::ST6: next_r.st = cpu_seq_pkg::ST1;
                default: next_r.st = cpu_seq_pkg::ST1;
            endcase
        end else begin
            next_r.cnt = r.cnt + 4'h1;
        end
    end

    // Register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '{cpu_seq_pkg::ST1, 4'h0};
        end else begin
            r <= next_r;
        end
    end

    assign tim.st = r.st;
    assign tim.last = (r.cnt == `CLKS_PER_STATE - 4'h1);

    cycle_len_a: assert property (@(posedge clk) disable iff (rst)
        (r.st == cpu_seq_pkg::ST1 && r.cnt == 4'h0) |-> ##12 (r.st == cpu_seq_pkg::ST1 && r.cnt == 4'h0))
        else $error("machine cycle is not twelve clocks");
endmodule

/* rtl/flag_unit.sv */
// Add, add-with-carry and subtract-with-borrow with half carry, carry and overflow
`timescale 1ns/1ps
module flag_unit (
    // Operation and operands
    input cpu_seq_pkg::arith_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic cy_in,
    // Result and flags
    output logic [7:0] res,
    output logic cy,
    output logic ac,
    output logic ov
);
    logic sub;
    logic ci;
    logic [7:0] b;
    logic [4:0] low;
    logic [8:0] sum;

    // Subtraction adds the complement; borrow is the inverted carry
    always_comb begin
        sub = (op == cpu_seq_pkg::AR_SUBB);
        b = sub ? ~opnd : opnd;
        ci = sub ? ~cy_in : ((op == cpu_seq_pkg::AR_ADDC) & cy_in);
        low = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        sum = {1'b0, acc} + {1'b0, b} + {8'h00, ci};
        res = sum[7:0];
        cy = sub ^ sum[8];
        ac = sub ^ low[4];
        ov = (acc[7] == b[7]) && (sum[7] != acc[7]);
    end
endmodule

/* rtl/cpu_cycle_seq.sv */
// Machine-cycle sequencer with program counter, external bus strobes and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cpu_seq_params.svh"
module cpu_cycle_seq (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // AXI4-Lite write address and data
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [7:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [7:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // Internal program ROM
    output logic [15:0] IROM_ADDR,
    input wire logic [7:0] IROM_DATA,
    // External memory bus
    output logic ALE,
    output logic PROG_FETCH_N,
    output logic RD_N,
    output logic WR_N,
    input wire logic [7:0] P0_IN,
    output logic [7:0] P0_OUT,
    output logic P0_OE,
    output logic [7:0] P2_OUT
);
    cpu_seq_pkg::core_t r;
    cpu_seq_pkg::core_t next_r;
    cpu_seq_pkg::timing_t tim;
    logic [7:0] alu_res;
    logic alu_cy;
    logic alu_ac;
    logic alu_ov;
    logic wr_go;
    logic pc_wr;
    logic strobe;
    logic ale_state;
    logic [7:0] fetch_byte;

    // ****************************************
    // Submodules
    // ****************************************
    state_divider u_div (
        .clk(SYS_CLK),
        .rst(RST),
        .tim(tim)
    );

    flag_unit u_flags (
        .op(r.info.arith),
        .acc(r.acc),
        .opnd(r.operand[15:8]),
        .cy_in(r.asw[`ASW_CY]),
        .res(alu_res),
        .cy(alu_cy),
        .ac(alu_ac),
        .ov(alu_ov)
    );

    // ****************************************
    // Helpers
    // ****************************************
    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] be);
        logic [31:0] m;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
        return m;
    endfunction

    // Register read mux; returns 0 for an unmapped offset
    function automatic logic reg_read(input cpu_seq_pkg::core_t s, input logic [5:0] st,
        input logic [7:0] a, output logic [31:0] d);
        logic hit;
        hit = 1'b1;
        d = 32'h00000000;
        case ({a[7:2], 2'h0})
            `OFS_CTRL: d = {30'h00000000, s.irom, s.run};
            `OFS_STATUS: d = {22'h000000, s.slot_ext, s.active, s.mc, st};
            `OFS_PC: d = {16'h0000, s.pc};
            `OFS_POINTER: d = {16'h0000, s.ptr};
            `OFS_ACC: d = {24'h000000, s.acc};
            `OFS_RI: d = {24'h000000, s.ri};
            `OFS_OPCODE: d = {8'h00, s.operand, s.opcode};
            `OFS_ASW: d = {24'h000000, s.asw};
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Write commit happens once both halves of a write are held
    assign wr_go = r.aw_held && r.w_held && !r.bvalid;
    assign pc_wr = wr_go && ({r.waddr[7:2], 2'h0} == `OFS_PC) && !r.run;
    // Data strobe spans M1 S6 through M2 S4 of an external data move
    assign strobe = r.active && (r.info.xmove != cpu_seq_pkg::XM_NONE) &&
        ((r.mc == 2'h0 && tim.st == cpu_seq_pkg::ST6) ||
        (r.mc == 2'h1 && tim.st inside {cpu_seq_pkg::ST1, cpu_seq_pkg::ST2,
        cpu_seq_pkg::ST3, cpu_seq_pkg::ST4}));
    assign ale_state = (tim.st == cpu_seq_pkg::ST5) ||
        (tim.st == cpu_seq_pkg::ST2 && !strobe);
    assign fetch_byte = r.slot_ext ? r.p0_s2 : IROM_DATA;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic [31:0] rd;
        logic [31:0] wv;
        logic hit;
        logic ext;
        rd = 32'h00000000;
        wv = 32'h00000000;
        hit = 1'b0;
        ext = 1'b0;
        next_r = r;
        // Two-flop synchroniser on the low port input
        next_r.p0_s1 = P0_IN;
        next_r.p0_s2 = r.p0_s1;

        // Write channel: capture address and data in any order
        if (AWVALID && r.awready) begin
            next_r.aw_held = 1'b1;
            next_r.waddr = AWADDR;
        end
        if (WVALID && r.wready) begin
            next_r.w_held = 1'b1;
            next_r.wdata = WDATA;
            next_r.wstrb = WSTRB;
        end
        if (r.bvalid && BREADY) begin
            next_r.bvalid = 1'b0;
        end
        if (wr_go) begin
            hit = reg_read(r, tim.st, r.waddr, rd);
            wv = merge(rd, r.wdata, r.wstrb);
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
            case ({r.waddr[7:2], 2'h0})
                `OFS_CTRL: begin
                    next_r.run = wv[`CTRL_RUN];
                    next_r.irom = wv[`CTRL_IROM];
                end
                `OFS_PC: if (!r.run) next_r.pc = wv[15:0];
                `OFS_POINTER: next_r.ptr = wv[15:0];
                `OFS_ACC: next_r.acc = wv[7:0];
                `OFS_RI: next_r.ri = wv[7:0];
                `OFS_ASW: next_r.asw = wv[7:0];
                default: next_r.run = r.run;
            endcase
        end
        next_r.awready = !next_r.aw_held && !next_r.bvalid;
        next_r.wready = !next_r.w_held && !next_r.bvalid;

        // Read channel: answer one cycle after the address is taken
        if (r.rvalid && RREADY) begin
            next_r.rvalid = 1'b0;
        end
        if (ARVALID && r.arready) begin
            hit = reg_read(r, tim.st, ARADDR, rd);
            next_r.rvalid = 1'b1;
            next_r.rdata = rd;
            next_r.rresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        next_r.arready = !next_r.rvalid;

        // Sequencer acts on the last clock of each state; hardware beats software
        if (tim.last) begin
            unique case (tim.st)
                cpu_seq_pkg::ST1: begin
                    if (r.mc == 2'h0 && r.run) begin
                        next_r.opcode = fetch_byte;
                        next_r.pc = r.pc + 16'h0001;
                        next_r.active = 1'b1;
                    end else if (r.mc == 2'h0) begin
                        next_r.active = 1'b0;
                        next_r.info = cpu_seq_pkg::DEC_IDLE;
                    end else if (r.mc == 2'h1 && r.active && r.info.nbytes == 2'h3) begin
                        next_r.operand[7:0] = fetch_byte;
                        next_r.pc = r.pc + 16'h0001;
                    end
                end
                cpu_seq_pkg::ST2: begin
                    if (r.active && r.mc == 2'h0) begin
                        next_r.info = cpu_seq_pkg::decode_array(r.opcode);
                    end
                end
                cpu_seq_pkg::ST3: next_r.mc = r.mc;
                cpu_seq_pkg::ST4: begin
                    if (r.active && r.mc == 2'h0 && r.info.nbytes != 2'h1) begin
                        next_r.operand[15:8] = fetch_byte;
                        next_r.pc = r.pc + 16'h0001;
                    end
                    if (r.active && r.mc == 2'h1 && r.info.xmove == cpu_seq_pkg::XM_READ) begin
                        next_r.acc = r.p0_s2;
                    end
                end
                cpu_seq_pkg::ST5: next_r.mc = r.mc;
                cpu_seq_pkg::ST6: begin
                    // Execution ends at S6 of the last machine cycle
                    if (!r.active || r.mc == r.info.last_mc) begin
                        next_r.mc = 2'h0;
                        if (r.active && r.info.arith != cpu_seq_pkg::AR_NONE) begin
                            next_r.acc = alu_res;
                            next_r.asw[`ASW_CY] = alu_cy;
                            next_r.asw[`ASW_AC] = alu_ac;
                            next_r.asw[`ASW_OV] = alu_ov;
                        end
                        if (r.active && r.info.load_acc) next_r.acc = r.operand[15:8];
                        if (r.active && r.info.load_ptr) next_r.ptr = r.operand;
                    end else begin
                        next_r.mc = r.mc + 2'h1;
                    end
                end
                default: next_r.mc = r.mc;
            endcase
            // Slot setup for the address phase that starts next (S2 or S5)
            if (tim.st == cpu_seq_pkg::ST1 || tim.st == cpu_seq_pkg::ST4) begin
                ext = !r.irom || (next_r.pc > `IROM_TOP);
                next_r.data_slot = (tim.st == cpu_seq_pkg::ST4) && r.active &&
                    r.mc == 2'h0 && r.info.xmove != cpu_seq_pkg::XM_NONE;
                next_r.slot_ext = ext && !next_r.data_slot;
                next_r.slot_addr = next_r.pc;
                if (next_r.data_slot) begin
                    next_r.slot_addr = r.info.use_ptr ? r.ptr : {r.p2_out, r.ri};
                end
            end
        end

        // Pins, registered one clock behind the state counter
        next_r.ale = ale_state;
        next_r.fetch_n = !(r.slot_ext && !strobe && tim.st inside {cpu_seq_pkg::ST3,
            cpu_seq_pkg::ST4, cpu_seq_pkg::ST6, cpu_seq_pkg::ST1});
        next_r.rd_n = !(strobe && r.info.xmove == cpu_seq_pkg::XM_READ);
        next_r.wr_n = !(strobe && r.info.xmove == cpu_seq_pkg::XM_WRITE);
        next_r.p0_oe = 1'b0;
        if (ale_state && (r.slot_ext || r.data_slot)) begin
            next_r.p0_out = r.slot_addr[7:0];
            next_r.p0_oe = 1'b1;
        end else if (strobe && r.info.xmove == cpu_seq_pkg::XM_WRITE) begin
            next_r.p0_out = r.acc;
            next_r.p0_oe = 1'b1;
        end
        // High port changes only at an address phase, so it holds through the access
        if (ale_state && (r.slot_ext || (r.data_slot && r.info.use_ptr))) begin
            next_r.p2_out = r.slot_addr[15:8];
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            r <= '0;
            r.pc <= `PC_RST;
            r.asw <= `ASW_RST;
            r.info <= cpu_seq_pkg::DEC_IDLE;
            r.bresp <= `RESP_OKAY;
            r.rresp <= `RESP_OKAY;
            r.ale <= 1'b1;
            r.fetch_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.wr_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign AWREADY = r.awready;
    assign WREADY = r.wready;
    assign BVALID = r.bvalid;
    assign BRESP = r.bresp;
    assign ARREADY = r.arready;
    assign RVALID = r.rvalid;
    assign RDATA = r.rdata;
    assign RRESP = r.rresp;
    assign IROM_ADDR = r.slot_addr;
    assign ALE = r.ale;
    assign PROG_FETCH_N = r.fetch_n;
    assign RD_N = r.rd_n;
    assign WR_N = r.wr_n;
    assign P0_OUT = r.p0_out;
    assign P0_OE = r.p0_oe;
    assign P2_OUT = r.p2_out;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    ale_pulse_a: assert property ($rose(ALE) |-> ALE ##1 ALE ##1 !ALE)
        else $error("address latch pulse is not two clocks");
    fetch_window_a: assert property ($fell(PROG_FETCH_N) |->
        !PROG_FETCH_N [*4] ##1 PROG_FETCH_N)
        else $error("program fetch window is not four clocks");
    strobe_quiet_a: assert property ((!RD_N || !WR_N) |-> PROG_FETCH_N && !ALE)
        else $error("latch or fetch strobe during a data strobe");
    read_strobe_a: assert property ($fell(RD_N) |->
        !RD_N [*8] ##1 !RD_N [*2] ##1 RD_N)
        else $error("read strobe is not ten clocks");
    write_drive_a: assert property (!WR_N |-> P0_OE && P0_OUT == r.acc)
        else $error("write data not driven during write strobe");
    pc_step_a: assert property ((r.pc != $past(r.pc) && !$past(pc_wr)) |->
        r.pc == $past(r.pc) + 16'h0001)
        else $error("program counter moved by other than one");
    // The slot's internal/external choice was made four clocks before its window opens
    rom_split_a: assert property ($fell(PROG_FETCH_N) |->
        (!$past(r.irom, 4) || r.slot_addr > `IROM_TOP))
        else $error("external fetch inside internal ROM range");
    ptr_high_a: assert property ((!RD_N && r.info.use_ptr) |->
        P2_OUT == r.ptr[15:8])
        else $error("high port not pointer high byte");
    mul_len_a: assert property ((r.active && r.info.last_mc == 2'h3 && tim.last &&
        tim.st == cpu_seq_pkg::ST6 && r.mc != 2'h3) |-> ##1 r.mc == $past(r.mc) + 2'h1)
        else $error("multiply cycle count broken");
endmodule

/* verification/ext_mem_model.sv */
// External program ROM, data RAM and address latch
`timescale 1ns/1ps
module ext_mem_model (
    // Strobes and ports from the device
    input wire logic clk,
    input wire logic ale,
    input wire logic fetch_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic p0_oe,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p2_out,
    input wire logic [15:0] irom_addr,
    // Data back to the device
    output logic [7:0] p0_in,
    output logic [7:0] irom_data
);
    logic [7:0] rom [0:65535];
    logic [7:0] ram [0:65535];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h00;
    wire [15:0] adr = {p2_out, lat};
    // Latch loads the low port on each clock edge while the strobe is high
    always @(posedge clk) begin
        if (ale) lat <= p0_out;
        if (!wr_n) ram[adr] <= p0_out;
        last <= p0_in;
    end
    // Released port toggles, so a stale byte is never mistaken for data
    assign p0_in = p0_oe ? p0_out : !fetch_n ? rom[adr] : !rd_n ? ram[adr] : ~last;
    assign irom_data = rom[irom_addr];
endmodule

/* verification/cpu_cycle_timing_and_bus_strobes_tb.sv */
// Self-checking bench for the machine-cycle sequencer
`timescale 1ns/1ps
`include "cpu_seq_params.svh"
module cpu_cycle_timing_and_bus_strobes_tb;
    logic SYS_CLK = 1'b0, RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0;
    logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, v, w;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hF;
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, ALE, PROG_FETCH_N, RD_N, WR_N, P0_OE;
    wire [1:0] BRESP, RRESP;
    wire [31:0] RDATA;
    wire [15:0] IROM_ADDR;
    wire [7:0] IROM_DATA, P0_IN, P0_OUT, P2_OUT;
    logic [33:0] eq [$];
    logic [8:0] s;
    logic [15:0] b;
    logic [7:0] pg [12];
    int error_cnt = 0, tests_run = 0, cyc = 0;
    cpu_cycle_seq uut (.SYS_CLK, .RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
        .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
        .RVALID, .RREADY, .RDATA, .RRESP, .IROM_ADDR, .IROM_DATA, .ALE, .PROG_FETCH_N,
        .RD_N, .WR_N, .P0_IN, .P0_OUT, .P0_OE, .P2_OUT);
    ext_mem_model mem (.clk(SYS_CLK), .ale(ALE), .fetch_n(PROG_FETCH_N), .rd_n(RD_N),
        .wr_n(WR_N), .p0_oe(P0_OE), .p0_out(P0_OUT), .p2_out(P2_OUT),
        .irom_addr(IROM_ADDR), .p0_in(P0_IN), .irom_data(IROM_DATA));
    // ****
    // Clock, checks and bus tasks
    // ****
    initial forever #5 SYS_CLK = ~SYS_CLK;
    task automatic end_of_test;
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Each channel held until its own ready, response taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        eq.push_back({r, 32'h0});
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        BREADY <= 1'b0;
        // One idle edge so a following call never re-raises a strobe in the same step
        @(posedge SYS_CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        eq.push_back(e);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        RREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    // Oldest note is matched against each response; a hang ends the run
    always @(posedge SYS_CLK) begin
        if (RVALID && RREADY) cmp({RRESP, RDATA}, eq.pop_front());
        if (BVALID && BREADY) cmp({BRESP, 32'h0}, eq.pop_front());
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test;
        end
    end
    // ****
    // Sequence: program straddles the wrap, then the internal ROM edge
    // ****
    initial begin
        v = $urandom(32'hA1A3CE82);
        for (int i = 0; i < 65536; i++) mem.rom[i] = 8'h00;
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        rd(`OFS_ASW, 34'h0);
        rd(`OFS_PC, 34'h0);
        rd(8'h40, {`RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1, `RESP_SLVERR);
        // Low byte lane only: the pointer high byte keeps its reset value
        WSTRB <= 4'h1;
        wr(`OFS_POINTER, 32'h0000ABCD, `RESP_OKAY);
        WSTRB <= 4'hF;
        rd(`OFS_POINTER, 34'h00CD);
        // Pass 0 adds, pass 1 subtracts with borrow; a multiply sits before the arithmetic
        for (int p = 0; p < 2; p++) begin
            b = p ? 16'h3FFD : 16'hFFFD;
            v = $urandom;
            w = $urandom;
            s = p ? v - w : v + w;
            pg = '{8'h74, v, 8'h90, 8'h12, 8'h34, 8'hF0, 8'h74, 8'h00, 8'hE0, 8'hA4,
                p ? 8'h94 : 8'h24, w};
            for (int i = 0; i < 12; i++) mem.rom[16'(b + i)] = pg[i];
            wr(`OFS_ASW, 32'h0, `RESP_OKAY);
            wr(`OFS_PC, {16'h0, b}, `RESP_OKAY);
            // A full machine cycle lets the fetch slot pick up the new counter
            repeat (12) @(posedge SYS_CLK);
            wr(`OFS_CTRL, {30'h0, p[0], 1'b1}, `RESP_OKAY);
            repeat (240) @(posedge SYS_CLK);
            wr(`OFS_CTRL, {30'h0, p[0], 1'b0}, `RESP_OKAY);
            repeat (40) @(posedge SYS_CLK);
            rd(`OFS_ACC, {26'h0, s[7:0]});
            rd(`OFS_ASW, {26'h0, s[8],
                (p[0] ? (v[3:0] < w[3:0]) : ({1'b0, v[3:0]} + w[3:0] > 5'h0F)), 3'h0,
                ((v[7] ^ w[7]) == p[0]) && (s[7] != v[7]), 2'h0});
            rd(`OFS_POINTER, {18'h0, 16'h1234});
            cmp({26'h0, mem.ram[16'h1234]}, {26'h0, v});
        end
        end_of_test;
    end
endmodule
